// >>> hw/ppmc_consts.svh
// Offsets, field positions and reset values for the port pin mode control block
`ifndef PPMC_CONSTS_SVH
`define PPMC_CONSTS_SVH
// ==================================================
// Register byte offsets
`define PPMC_OFF_P0_OUT 12'h000
`define PPMC_OFF_P1_OUT 12'h004
`define PPMC_OFF_P2_OUT 12'h008
`define PPMC_OFF_P3_OUT 12'h00C
`define PPMC_OFF_P4_OUT 12'h010
`define PPMC_OFF_P5_OUT 12'h014
`define PPMC_OFF_P6_OUT 12'h018
`define PPMC_OFF_P0_DIR 12'h020
`define PPMC_OFF_P1_DIR 12'h024
`define PPMC_OFF_P2_DIR 12'h028
`define PPMC_OFF_P3_DIR 12'h02C
`define PPMC_OFF_P5_DIR 12'h034
`define PPMC_OFF_P6_DIR 12'h038
`define PPMC_OFF_PUO 12'h040
`define PPMC_OFF_MEMX 12'h044
`define PPMC_OFF_CTRL 12'h048
`define PPMC_OFF_EDGE 12'h04C
`define PPMC_OFF_FLAG 12'h050
`define PPMC_OFF_P0_IN 12'h060
`define PPMC_OFF_P1_IN 12'h064
`define PPMC_OFF_P2_IN 12'h068
`define PPMC_OFF_P3_IN 12'h06C
`define PPMC_OFF_P4_IN 12'h070
`define PPMC_OFF_P5_IN 12'h074
`define PPMC_OFF_P6_IN 12'h078
// ==================================================
// Memory extension register fields
`define PPMC_MEMX_P4_OUT 0
`define PPMC_MEMX_EXT_EN 1
`define PPMC_MEMX_WAIT_EN 2
// Flag register fields
`define PPMC_FLAG_P4_FALL 0
// ==================================================
// Reset values
`define PPMC_RST_DIR 8'hFF
`define PPMC_RST_OUT 8'h00
`define PPMC_RST_PUO 8'h00
`endif

// >>> hw/ppmc_pkg.sv
// Types shared by the port pin mode control block
package ppmc_pkg;
    typedef logic [7:0] ppmc_byte_t;
    typedef enum logic [1:0] {
        PPMC_EDGE_FALL,
        PPMC_EDGE_RISE,
        PPMC_EDGE_BOTH,
        PPMC_EDGE_NONE
    } ppmc_edge_e;
endpackage

// >>> hw/ppmc_edge_detect.sv
// Selectable edge detector for one external interrupt input
`timescale 1ns/10ps
module ppmc_edge_detect
    import ppmc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pin sample and edge mode
    input wire logic pin_in,
    input wire logic [1:0] edge_sel,
    // Detected valid edge
    output logic edge_pulse
);
    typedef struct packed {
        logic prev;
        logic pulse;
    } ppmc_ed_s;
    ppmc_ed_s st_reg;
    ppmc_ed_s st_next;

    // ==================================================
    // Edge compare
    always_comb begin
        logic rise;
        logic fall;
        rise = pin_in & ~st_reg.prev;
        fall = ~pin_in & st_reg.prev;
        st_next.prev = pin_in;
        case (ppmc_edge_e'(edge_sel))
            PPMC_EDGE_FALL: st_next.pulse = fall;
            PPMC_EDGE_RISE: st_next.pulse = rise;
            PPMC_EDGE_BOTH: st_next.pulse = rise | fall;
            default: st_next.pulse = 1'b0;
        endcase
    end

    // State register; previous level resets high so no false rise appears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{prev: 1'b1, pulse: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign edge_pulse = st_reg.pulse;
endmodule

// >>> hw/ppmc_top.sv
// Port pin mode control: seven ports, pull-ups, edge detect, APB registers
//
// Summary of operation
// - Port 0 bits 0 and 4 input only.
// - Port 0 bits 1-3 direction per bit.
// - Port 0 pull-up only as enabled input.
// - Interrupts 0-2 detect selected valid edge.
// - Interrupt 0 edge also triggers timer capture.
// - Interrupt 3 raises on falling edge only.
// - Analog port 1 pins drop their pull-up.
// - Port 2 direction set per bit.
// - Port 4 falling edge sets test flag.
// - Port 4 direction set as whole byte.
// - Memory mode: port 4 carries address/data, no pull-up.
// - Memory mode: port 5 drives high address.
// - Ports 1,3,5,6 direction per bit.
// - Port 6 bits 0-3 open drain, no pull-up.
// - Port 6 bits 4-7 pull-up as enabled input.
// - Memory mode: port 6 bits 4, 5 and 7 carry strobes.
// - Without wait, port 6 bit 6 stays port.
// - Low reset input resets the block.
`timescale 1ns/10ps
`include "ppmc_consts.svh"
module ppmc_top
    import ppmc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,

    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // Port pins, input levels
    input wire logic [4:0] port0_in,
    input wire logic [7:0] port1_in,
    input wire logic [7:0] port2_in,
    input wire logic [7:0] port3_in,
    input wire logic [7:0] port4_in,
    input wire logic [7:0] port5_in,
    input wire logic [7:0] port6_in,

    // Port pins, output levels
    output logic [4:0] port0_out,
    output logic [7:0] port1_out,
    output logic [7:0] port2_out,
    output logic [7:0] port3_out,
    output logic [7:0] port4_out,
    output logic [7:0] port5_out,
    output logic [7:0] port6_out,

    // Port pins, output enables
    output logic [4:0] port0_oe,
    output logic [7:0] port1_oe,
    output logic [7:0] port2_oe,
    output logic [7:0] port3_oe,
    output logic [7:0] port4_oe,
    output logic [7:0] port5_oe,
    output logic [7:0] port6_oe,

    // Pull-up enables
    output logic [4:0] port0_pullup,
    output logic [7:0] port1_pullup,
    output logic [7:0] port2_pullup,
    output logic [7:0] port3_pullup,
    output logic [7:0] port4_pullup,
    output logic [7:0] port5_pullup,
    output logic [7:0] port6_pullup,

    // Alternate functions: A/D, serial, timers
    input wire logic [7:0] analog_inputs,
    input wire logic [7:0] port2_ctrl_sel,
    input wire logic [7:0] port2_ctrl_out,
    input wire logic [7:0] port2_ctrl_oe,
    input wire logic [7:0] port3_ctrl_sel,
    input wire logic [7:0] port3_ctrl_out,

    // External memory bus
    input wire logic [7:0] low_addr_data_bus,
    input wire logic low_addr_data_oe,
    input wire logic [7:0] high_addr_bus,
    input wire logic mem_read_strobe,
    input wire logic mem_write_strobe,
    input wire logic addr_latch_strobe,
    output logic mem_wait_in,

    // Events
    output logic [3:0] ext_irq_req,
    output logic timer16_capture,
    output logic timer16_count_in,
    output logic port4_falling_edge_flag
);
    typedef struct packed {
        logic [6:0][7:0] out_latch;
        logic [7:0] port0_direction;
        logic [7:0] port1_direction;
        logic [7:0] port2_direction;
        logic [7:0] port3_direction;
        logic [7:0] port5_direction;
        logic [7:0] port6_direction;
        logic [7:0] pullup_option;
        logic [2:0] memory_extension_mode;
        logic [7:0] edge_select;
        logic [7:0] p4_prev;
        logic fall_flag;
        logic [31:0] rdata;
    } ppmc_state_s;

    ppmc_state_s st_reg;
    ppmc_state_s st_next;

    logic [3:0] edge_pulse;
    logic mem_ext;
    logic wait_used;
    logic p4_out_mode;
    logic [7:0] p4_fall;

    // ==================================================
    // Address decode helpers
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    // Pull-up term: enabled only for an input with the port's option set
    function automatic logic [7:0] pullup_of(input logic en, input logic [7:0] dir_in);
        return en ? dir_in : 8'h00;
    endfunction

    // ==================================================
    // Mode decode
    assign mem_ext = st_reg.memory_extension_mode[`PPMC_MEMX_EXT_EN];
    assign wait_used = mem_ext & st_reg.memory_extension_mode[`PPMC_MEMX_WAIT_EN];
    assign p4_out_mode = st_reg.memory_extension_mode[`PPMC_MEMX_P4_OUT];
    assign p4_fall = st_reg.p4_prev & ~port4_in;

    // ==================================================
    // External interrupt edge detectors, inputs 0-2 selectable
    genvar gi;

    generate
        for (gi = 0; gi < 3; gi++) begin : g_irq
            ppmc_edge_detect u_edge (
                .pclk(pclk),
                .presetn(presetn),
                .pin_in(port0_in[gi]),
                .edge_sel(st_reg.edge_select[2*gi+:2]),
                .edge_pulse(edge_pulse[gi])
            );
        end
    endgenerate

    // Input 3 fixed to the falling edge
    ppmc_edge_detect u_edge3 (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(port0_in[3]),
        .edge_sel(2'(PPMC_EDGE_FALL)),
        .edge_pulse(edge_pulse[3])
    );

    assign ext_irq_req = edge_pulse;
    assign timer16_capture = edge_pulse[0];
    assign timer16_count_in = port0_in[0];
    assign port4_falling_edge_flag = st_reg.fall_flag;

    // ==================================================
    // Register update and bus reads
    always_comb begin
        logic wr;
        logic rd;
        st_next = st_reg;
        wr = psel & penable & pwrite;
        rd = psel & ~penable & ~pwrite;

        st_next.p4_prev = port4_in;

        // Hardware set wins over a same-cycle clear
        if (wr && addr_hit(paddr, `PPMC_OFF_FLAG) && pwdata[`PPMC_FLAG_P4_FALL]) begin
            st_next.fall_flag = 1'b0;
        end
        if (|p4_fall) begin
            st_next.fall_flag = 1'b1;
        end

        if (wr) begin
            for (int i = 0; i < 7; i++) begin
                if (addr_hit(paddr, 12'(`PPMC_OFF_P0_OUT + 4 * i))) begin
                    st_next.out_latch[i] = pwdata[7:0];
                end
            end

            if (addr_hit(paddr, `PPMC_OFF_P0_DIR)) st_next.port0_direction = pwdata[7:0];
            if (addr_hit(paddr, `PPMC_OFF_P1_DIR)) st_next.port1_direction = pwdata[7:0];
            if (addr_hit(paddr, `PPMC_OFF_P2_DIR)) st_next.port2_direction = pwdata[7:0];
            if (addr_hit(paddr, `PPMC_OFF_P3_DIR)) st_next.port3_direction = pwdata[7:0];
            if (addr_hit(paddr, `PPMC_OFF_P5_DIR)) st_next.port5_direction = pwdata[7:0];
            if (addr_hit(paddr, `PPMC_OFF_P6_DIR)) st_next.port6_direction = pwdata[7:0];
            if (addr_hit(paddr, `PPMC_OFF_PUO)) st_next.pullup_option = pwdata[7:0];
            if (addr_hit(paddr, `PPMC_OFF_MEMX)) st_next.memory_extension_mode = pwdata[2:0];
            if (addr_hit(paddr, `PPMC_OFF_EDGE)) st_next.edge_select = pwdata[7:0];
        end

        // Read data loaded in setup, valid in access
        if (rd) begin
            st_next.rdata = 32'h0000_0000;
            for (int i = 0; i < 7; i++) begin
                if (addr_hit(paddr, 12'(`PPMC_OFF_P0_OUT + 4 * i))) begin
                    st_next.rdata[7:0] = st_reg.out_latch[i];
                end
            end

            case (paddr)
                `PPMC_OFF_P0_DIR: st_next.rdata[7:0] = st_reg.port0_direction;
                `PPMC_OFF_P1_DIR: st_next.rdata[7:0] = st_reg.port1_direction;
                `PPMC_OFF_P2_DIR: st_next.rdata[7:0] = st_reg.port2_direction;
                `PPMC_OFF_P3_DIR: st_next.rdata[7:0] = st_reg.port3_direction;
                `PPMC_OFF_P5_DIR: st_next.rdata[7:0] = st_reg.port5_direction;
                `PPMC_OFF_P6_DIR: st_next.rdata[7:0] = st_reg.port6_direction;
                `PPMC_OFF_PUO: st_next.rdata[7:0] = st_reg.pullup_option;
                `PPMC_OFF_MEMX: st_next.rdata[2:0] = st_reg.memory_extension_mode;
                `PPMC_OFF_EDGE: st_next.rdata[7:0] = st_reg.edge_select;
                `PPMC_OFF_FLAG: st_next.rdata[0] = st_reg.fall_flag;
                `PPMC_OFF_P0_IN: st_next.rdata[4:0] = port0_in;
                `PPMC_OFF_P1_IN: st_next.rdata[7:0] = port1_in;
                `PPMC_OFF_P2_IN: st_next.rdata[7:0] = port2_in;
                `PPMC_OFF_P3_IN: st_next.rdata[7:0] = port3_in;
                `PPMC_OFF_P4_IN: st_next.rdata[7:0] = port4_in;
                `PPMC_OFF_P5_IN: st_next.rdata[7:0] = port5_in;
                `PPMC_OFF_P6_IN: st_next.rdata[7:0] = port6_in;
                default: st_next.rdata[7:0] = st_next.rdata[7:0];
            endcase
        end
    end

    // State register; every pin starts as an undriven input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.out_latch <= {7{`PPMC_RST_OUT}};

            st_reg.port0_direction <= `PPMC_RST_DIR;
            st_reg.port1_direction <= `PPMC_RST_DIR;
            st_reg.port2_direction <= `PPMC_RST_DIR;
            st_reg.port3_direction <= `PPMC_RST_DIR;
            st_reg.port5_direction <= `PPMC_RST_DIR;
            st_reg.port6_direction <= `PPMC_RST_DIR;

            st_reg.pullup_option <= `PPMC_RST_PUO;
            st_reg.memory_extension_mode <= 3'h0;
            st_reg.edge_select <= 8'h00;

            st_reg.p4_prev <= 8'hFF;
            st_reg.fall_flag <= 1'b0;
            st_reg.rdata <= 32'h0000_0000;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==================================================
    // APB answers: zero wait states, unmapped reads return zero
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    assign prdata = st_reg.rdata;

    // ==================================================
    // Port 0: bits 0 and 4 input only, bits 1-3 per-bit direction
    assign port0_out = st_reg.out_latch[0][4:0];
    assign port0_oe = {1'b0, ~st_reg.port0_direction[3:1], 1'b0};
    assign port0_pullup = 5'(pullup_of(st_reg.pullup_option[0],
                                       st_reg.port0_direction | 8'h11));

    // Port 1: per-bit direction, analog pins drop their pull-up
    assign port1_out = st_reg.out_latch[1];
    assign port1_oe = ~st_reg.port1_direction;
    assign port1_pullup = pullup_of(st_reg.pullup_option[1], st_reg.port1_direction)
                          & ~analog_inputs;

    // Port 2: per-bit direction; serial functions take the driver when selected
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (port2_ctrl_sel[i]) begin
                port2_out[i] = port2_ctrl_out[i];
                port2_oe[i] = port2_ctrl_oe[i] & ~st_reg.port2_direction[i];
            end else begin
                port2_out[i] = st_reg.out_latch[2][i];
                port2_oe[i] = ~st_reg.port2_direction[i];
            end
        end
    end
    assign port2_pullup = pullup_of(st_reg.pullup_option[2], st_reg.port2_direction);

    // Port 3: per-bit direction, timer/clock/buzzer outputs replace the latch
    assign port3_out = (port3_ctrl_sel & port3_ctrl_out)
                       | (~port3_ctrl_sel & st_reg.out_latch[3]);
    assign port3_oe = ~st_reg.port3_direction;
    assign port3_pullup = pullup_of(st_reg.pullup_option[3], st_reg.port3_direction);

    // Port 4: whole-byte direction, address/data in memory mode
    assign port4_out = mem_ext ? low_addr_data_bus : st_reg.out_latch[4];
    assign port4_oe = mem_ext ? {8{low_addr_data_oe}} : {8{p4_out_mode}};
    assign port4_pullup = mem_ext ? 8'h00
                          : pullup_of(st_reg.pullup_option[4], {8{~p4_out_mode}});

    // Port 5: per-bit direction, high address in memory mode
    assign port5_out = mem_ext ? high_addr_bus : st_reg.out_latch[5];
    assign port5_oe = mem_ext ? 8'hFF : ~st_reg.port5_direction;
    assign port5_pullup = mem_ext ? 8'h00
                          : pullup_of(st_reg.pullup_option[5], st_reg.port5_direction);

    // Port 6: low nibble open drain, bits 4, 5 and 7 carry memory strobes
    always_comb begin
        logic [7:0] oe6;
        logic [7:0] pu6;
        oe6 = ~st_reg.port6_direction;
        pu6 = pullup_of(st_reg.pullup_option[6], st_reg.port6_direction);
        port6_out = st_reg.out_latch[6];
        port6_out[3:0] = 4'h0;
        oe6[3:0] = ~st_reg.port6_direction[3:0] & ~st_reg.out_latch[6][3:0];
        pu6[3:0] = 4'h0;

        if (mem_ext) begin
            port6_out[4] = mem_read_strobe;
            port6_out[5] = mem_write_strobe;
            port6_out[7] = addr_latch_strobe;
            oe6[4] = 1'b1;
            oe6[5] = 1'b1;
            oe6[7] = 1'b1;

            pu6[4] = 1'b0;
            pu6[5] = 1'b0;
            pu6[7] = 1'b0;

            if (wait_used) begin
                oe6[6] = 1'b0;
                pu6[6] = 1'b0;
            end
        end

        port6_oe = oe6;
        port6_pullup = pu6;
    end

    // Wait input is only seen when the wait function is enabled
    assign mem_wait_in = wait_used & port6_in[6];
endmodule

// >>> sim/ppmc_top_assertions.sv
// Concurrent checks on the ports of the port pin mode control block
`timescale 1ns/10ps
`include "ppmc_consts.svh"
module ppmc_top_chk
    import ppmc_pkg::*;
(
    // Clock, reset and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // Pins
    input wire logic [4:0] port0_in,
    input wire logic [7:0] port4_in,
    input wire logic [4:0] port0_oe,
    input wire logic [7:0] port1_oe,
    input wire logic [7:0] port6_oe,
    input wire logic [7:0] port5_out,
    input wire logic [7:0] port6_out,
    input wire logic [7:0] port1_pullup,
    input wire logic [7:0] port4_pullup,
    input wire logic [7:0] port5_pullup,
    input wire logic [7:0] port6_pullup,
    // Alternate functions and events
    input wire logic [7:0] analog_inputs,
    input wire logic [7:0] high_addr_bus,
    input wire logic mem_read_strobe,
    input wire logic mem_wait_in,
    input wire logic [3:0] ext_irq_req,
    input wire logic timer16_capture,
    input wire logic port4_falling_edge_flag
);
    // ==================================================
    // Memory mode as written
    logic [2:0] memx_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            memx_q <= 3'h0;
        end else if (psel && penable && pwrite && paddr == `PPMC_OFF_MEMX) begin
            memx_q <= pwdata[2:0];
        end
    end
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==================================================
    // Pin properties
    property p_in_only; port0_oe[0] == 1'h0 && port0_oe[4] == 1'h0; endproperty
    a_in_only: assert property (p_in_only)
        else $error("port 0 input pin driven");
    property p_analog; (analog_inputs & port1_pullup) == 8'h00; endproperty
    a_analog: assert property (p_analog)
        else $error("analog pin pulled up");
    property p_capture; timer16_capture == ext_irq_req[0]; endproperty
    a_capture: assert property (p_capture)
        else $error("capture differs from irq 0");
    property p_irq3;
        ext_irq_req[3] |-> $past(port0_in[3], 1) == 1'h0 && $past(port0_in[3], 2) == 1'h1;
    endproperty
    a_irq3: assert property (p_irq3)
        else $error("irq 3 without fall");
    property p_p4_flag;
        (|($past(port4_in) & ~port4_in)) |-> ##[1:2] port4_falling_edge_flag;
    endproperty
    a_p4_flag: assert property (p_p4_flag)
        else $error("port 4 flag not set");
    property p_p4_mem; memx_q[1] |-> port4_pullup == 8'h00; endproperty
    a_p4_mem: assert property (p_p4_mem)
        else $error("port 4 pulled up");
    property p_p5_mem; memx_q[1] |-> port5_out == high_addr_bus && port5_pullup == 8'h00; endproperty
    a_p5_mem: assert property (p_p5_mem)
        else $error("port 5 not high address");
    property p_p6_od; port6_pullup[3:0] == 4'h0 && (port6_oe[3:0] & port6_out[3:0]) == 4'h0; endproperty
    a_p6_od: assert property (p_p6_od)
        else $error("open-drain pin high");
    property p_strobe; memx_q[1] |-> port6_out[4] == mem_read_strobe && !port6_pullup[4]; endproperty
    a_strobe: assert property (p_strobe)
        else $error("read strobe not on port 6");
    property p_no_wait; !memx_q[2] |-> !mem_wait_in; endproperty
    a_no_wait: assert property (p_no_wait)
        else $error("unused wait active");
    property p_rst;
        $rose(presetn) |-> port0_oe == 5'h00 && port1_oe == 8'h00 && port6_oe == 8'h00;
    endproperty
    a_rst: assert property (p_rst)
        else $error("pin driven after reset");
endmodule

bind ppmc_top ppmc_top_chk chk (.*);

// >>> sim/ppmc_pin_model.sv
// Board-side model of the port pins
`timescale 1ns/10ps
module ppmc_pin_model #(
    parameter int W = 53
) (
    // Clock
    input wire logic clk,
    // Device side
    input wire logic [W-1:0] dev_out,
    input wire logic [W-1:0] dev_oe,
    input wire logic [W-1:0] pu,
    // Far side drivers
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en,
    // Resolved pin levels
    output logic [W-1:0] pin
);
    logic [W-1:0] last = '0;
    // Device, outside driver, pull-up, else a level that keeps moving
    assign pin = (dev_oe & dev_out) | (~dev_oe & ext_en & ext_val)
        | (~dev_oe & ~ext_en & (pu | ~last));
    // Last level seen
    always_ff @(posedge clk) begin
        last <= pin;
    end
endmodule

// >>> sim/test_port_pin_mode_control.sv
// Self-checking bench for the port pin mode control block
`timescale 1ns/10ps
`include "ppmc_consts.svh"
module test_port_pin_mode_control
    import ppmc_pkg::*;
;
    logic pclk = 1'h0;
    logic presetn, psel, penable, pwrite, pready, pslverr, low_addr_data_oe, mem_wait_in;
    logic mem_read_strobe, mem_write_strobe, addr_latch_strobe, timer16_capture;
    logic timer16_count_in, port4_falling_edge_flag;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [4:0] port0_in, port0_out, port0_oe, port0_pullup;
    logic [7:0] port1_in, port2_in, port3_in, port4_in, port5_in, port6_in;
    logic [7:0] port1_out, port2_out, port3_out, port4_out, port5_out, port6_out;
    logic [7:0] port1_oe, port2_oe, port3_oe, port4_oe, port5_oe, port6_oe;
    logic [7:0] port1_pullup, port2_pullup, port3_pullup, port4_pullup, port5_pullup, port6_pullup;
    logic [7:0] analog_inputs, port2_ctrl_sel, port2_ctrl_out, port2_ctrl_oe, port3_ctrl_sel;
    logic [7:0] port3_ctrl_out, low_addr_data_bus, high_addr_bus;
    logic [3:0] ext_irq_req;
    logic [52:0] ext_val, ext_en, pin, oe_all, out_all;
    logic [3:0][3:0] ic = '0;
    int pl[5] = '{1, 2, 3, 5, 6};
    int err_count = 0;
    int check_count = 0;
    // ==================================================
    // Design, outside pins and clock
    assign oe_all = {port6_oe, port5_oe, port4_oe, port3_oe, port2_oe, port1_oe, port0_oe};
    assign out_all = {port6_out, port5_out, port4_out, port3_out, port2_out, port1_out, port0_out};
    assign {port6_in, port5_in, port4_in, port3_in, port2_in, port1_in, port0_in} = pin;
    ppmc_top uut (.*);
    ppmc_pin_model #(.W(53)) pins (.clk(pclk), .dev_out(out_all), .dev_oe(oe_all),
        .pu({port6_pullup, port5_pullup, port4_pullup, port3_pullup, port2_pullup,
        port1_pullup, port0_pullup}), .ext_val(ext_val), .ext_en(ext_en), .pin(pin));
    always #4 pclk = ~pclk;
    // Interrupt pulse counts
    always @(posedge pclk) begin
        for (int i = 0; i < 4; i++) begin
            ic[i] <= ic[i] + {3'h0, ext_irq_req[i]};
        end
    end
    // ==================================================
    // Tasks
    task automatic finish_test();
        $display("Checks %0d, errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // APB transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n == 20) begin
            err_count++;
            finish_test();
        end
        q = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'h1, a, d, q);
    endtask
    task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'h0, a, 32'h0, q);
        chk(name, exp, q);
    endtask
    function automatic logic [7:0] sl(input logic [52:0] v, input int p);
        return 8'(v >> ((p == 0) ? 0 : 8 * p - 3));
    endfunction
    // ==================================================
    // Main sequence
    initial begin
        logic [7:0] e;
        logic [3:0] e4;
        logic [15:0] q4;
        presetn = 1'h0;
        {psel, penable, pwrite, low_addr_data_oe, mem_read_strobe} = 5'h00;
        {mem_write_strobe, addr_latch_strobe, paddr, pwdata} = 46'h0;
        {analog_inputs, port2_ctrl_sel, port2_ctrl_out, port2_ctrl_oe} = 32'h0;
        {port3_ctrl_sel, port3_ctrl_out, low_addr_data_bus, high_addr_bus} = 32'h0;
        ext_val = {53{1'h1}};
        ext_en = {53{1'h1}};
        cyc(10);
        presetn <= 1'h1;
        cyc(1);
        chk("oe_any", 32'h0, {31'h0, |oe_all});
        rd("p1_dir", `PPMC_OFF_P1_DIR, 32'hFF);
        wr(12'hFFC, 32'hFFFF_FFFF);
        rd("unmapped", 12'hFFC, 32'h0);
        // Per-bit directions
        foreach (pl[i]) begin
            wr(12'(4 * pl[i]), 32'hA5);
            wr(12'(32 + 4 * pl[i]), 32'h3C);
        end
        wr(`PPMC_OFF_P0_OUT, 32'h1F);
        wr(`PPMC_OFF_P0_DIR, 32'h00);
        cyc(1);
        foreach (pl[i]) begin
            e = (pl[i] == 6) ? 8'hC2 : 8'hC3;
            chk("dir_oe", {24'h0, e}, {24'h0, sl(oe_all, pl[i])});
            chk("dir_out", {24'h0, e & 8'hA5}, {24'h0, sl(oe_all & out_all, pl[i])});
        end
        chk("p0_oe", 32'h0E, {27'h0, port0_oe});
        rd("p2_in", `PPMC_OFF_P2_IN, 32'hBD);
        // Alternate functions own pins
        wr(`PPMC_OFF_P2_DIR, 32'h00);
        wr(`PPMC_OFF_P2_OUT, 32'hFF);
        wr(`PPMC_OFF_P3_DIR, 32'h00);
        port2_ctrl_sel <= 8'h0F;
        port2_ctrl_out <= 8'h05;
        port2_ctrl_oe <= 8'h0F;
        port3_ctrl_sel <= 8'hF0;
        port3_ctrl_out <= 8'hA0;
        cyc(1);
        chk("p2_alt", 32'hF5, {24'h0, port2_out});
        chk("p3_alt", 32'hA5, {24'h0, port3_out});
        // Pull-ups
        wr(`PPMC_OFF_P0_DIR, 32'h0A);
        wr(`PPMC_OFF_PUO, 32'h7F);
        analog_inputs <= 8'h0F;
        cyc(1);
        chk("p0_pu", 32'h5, {29'h0, port0_pullup[3:1]});
        chk("p1_pu", 32'h30, {24'h0, port1_pullup});
        chk("p6_pu", 32'h30, {24'h0, port6_pullup});
        chk("p4_pu", 32'hFF, {24'h0, port4_pullup});
        // Port 4 direction and flag
        wr(`PPMC_OFF_P4_OUT, 32'h3C);
        wr(`PPMC_OFF_MEMX, 32'h1);
        cyc(1);
        chk("p4_oe", 32'hFF, {24'h0, port4_oe});
        chk("p4_out", 32'h3C, {24'h0, port4_out});
        wr(`PPMC_OFF_MEMX, 32'h0);
        wr(`PPMC_OFF_FLAG, 32'h1);
        rd("flag_clr", `PPMC_OFF_FLAG, 32'h0);
        ext_val[36:29] <= 8'hF7;
        cyc(3);
        rd("flag_set", `PPMC_OFF_FLAG, 32'h1);
        // Memory extension mode
        wr(`PPMC_OFF_P6_DIR, 32'h7C);
        high_addr_bus <= 8'h5A;
        low_addr_data_bus <= 8'hC3;
        low_addr_data_oe <= 1'h1;
        mem_read_strobe <= 1'h1;
        wr(`PPMC_OFF_MEMX, 32'h2);
        cyc(1);
        chk("p4_ad", 32'hC3, {24'h0, port4_out & port4_oe});
        chk("p4_mpu", 32'h0, {24'h0, port4_pullup});
        chk("p5_addr", 32'h5A, {24'h0, port5_out});
        chk("rd_strobe", 32'h1, {31'h0, port6_out[4]});
        chk("wait_off", 32'h0, {31'h0, mem_wait_in});
        wr(`PPMC_OFF_MEMX, 32'h6);
        cyc(2);
        chk("wait_on", 32'h1, {31'h0, mem_wait_in});
        wr(`PPMC_OFF_MEMX, 32'h0);
        // Interrupt edge modes
        wr(`PPMC_OFF_P0_DIR, 32'h1F);
        ext_val[3:0] <= 4'h0;
        cyc(4);
        for (int m = 0; m < 4; m++) begin
            wr(`PPMC_OFF_EDGE, 32'(m * 21));
            cyc(2);
            q4 = ic;
            ext_val[3:0] <= 4'hF;
            cyc(4);
            ext_val[3:0] <= 4'h0;
            cyc(4);
            e4 = (m == 2) ? 4'h2 : ((m == 3) ? 4'h0 : 4'h1);
            chk("irq_cnt", {16'h0, 4'h1, e4, e4, e4}, {16'h0, ic - q4});
        end
        finish_test();
    end
endmodule
